/* core/afs_pkg.sv */
// Package for the amplifier fault supervisor: types, bit positions and timing counts
package afs_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 40000000;   // System clock rate
  localparam int OFFSET_QUAL_MS  = 100;        // Offset must persist this long
  localparam int WINDOW_QUAL_MS  = 100;        // Output in sense window this long
  localparam int OFFSET_QUAL_CYC = (CLK_HZ / 1000) * OFFSET_QUAL_MS;
  localparam int WINDOW_QUAL_CYC = (CLK_HZ / 1000) * WINDOW_QUAL_MS;
  localparam int OC_PERSIST_PWM  = 4;          // PWM periods of cycle-by-cycle limiting
  localparam int DIAG_QUAL_MS    = 100;        // Diagnostic test window
  localparam int DIAG_QUAL_CYC   = (CLK_HZ / 1000) * DIAG_QUAL_MS;
  localparam int CNT_W           = 23;         // Wide enough for 4,000,000

  // ---------------------------------------------------------------
  // Operating mode pins
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_BUSFREE_NODIAG = 2'h0; // No bus, no power-up diagnostic
  localparam logic [1:0] MODE_BUSFREE_DIAG   = 2'h1; // No bus, automatic diagnostic
  localparam logic [1:0] MODE_BUS_A          = 2'h2; // Bus active
  localparam logic [1:0] MODE_BUS_B          = 2'h3; // Bus active

  // ---------------------------------------------------------------
  // Fault register bit positions
  // ---------------------------------------------------------------
  localparam int F1_SHORT_GND = 0;   // Output shorted to ground
  localparam int F1_SHORT_VS  = 1;   // Output shorted to supply
  localparam int F1_SHORT_LD  = 2;   // Shorted transducer
  localparam int F1_OPEN_LD   = 3;   // Open transducer
  localparam int F1_DIAG_RUN  = 4;   // Diagnostic start / running bit
  localparam int F2_OFFSET    = 0;   // DC offset
  localparam int F2_TWARN     = 1;   // Die temperature warning
  localparam int F2_EXT_TWARN = 2;   // External temperature warning
  localparam int F2_CLIP      = 3;   // Clipping
  localparam int F2_OUT_TRIP  = 4;   // Output current trip
  localparam int F2_SUP_TRIP  = 5;   // Supply current trip
  localparam int FREG_W       = 8;   // Register width
  localparam logic [7:0] FREG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Grouped analog comparator results
  // ---------------------------------------------------------------
  typedef struct packed {
    logic offset_over;     // |bridge_out_a - bridge_out_b| above 3V
    logic out_in_window;   // Output within +/-1.2V
    logic die_th1;         // Die temperature first threshold
    logic die_th2;         // Die temperature second threshold
    logic ext_th1;         // Thermistor input first threshold
    logic ext_th2;         // Thermistor input second threshold
    logic max_mod;         // Maximum modulation reached
    logic analog_output_clip;       // Analog output clipping
    logic oc_th1;          // Qualified drain-source above first threshold
    logic oc_th2;          // Qualified drain-source above second threshold
    logic sup_over;        // Supply sense above threshold
    logic diag_gnd;        // Diagnostic comparators
    logic diag_vs;
    logic diag_short;
    logic diag_open;
  } afs_sense_t;

  // Diagnostic sequencer states
  typedef enum logic [1:0] {
    AFS_IDLE,
    AFS_TEST,
    AFS_DONE
  } afs_diag_t;

endpackage

/* core/afs_supervisor.sv */
// Fault supervisor: latched fault flags, protection actions and fault pins
`timescale 1ns/1ps

module afs_supervisor (
  // Clock, reset, enable
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // Mode and straps (pins, asynchronous)
  input  wire logic [1:0]             mode_pins,
  input  wire logic                   latch_enable_strap,
  input  wire logic                   standby,
  input  wire logic                   converter_enable,
  input  wire logic                   pwm_period_tick,
  // Analog comparator results (asynchronous)
  input  wire afs_pkg::afs_sense_t    sense,
  // Host register access (same clock)
  input  wire logic                   wr_reg_one,
  input  wire logic                   wr_reg_two,
  input  wire logic [7:0]             wr_data,
  input  wire logic                   thyristor_enable_bit,
  output logic [7:0]                  fault_reg_one,
  output logic [7:0]                  fault_reg_two,
  // Protection outputs
  output logic                        modulator_tristate,
  output logic                        current_inject,
  output logic                        power_latch_thyristor,
  output logic                        sense_switch_open,
  output logic                        i2c_addr0_force_zero,
  // Open-drain pins: low drive enables
  output logic                        clip_flag_pin_o,
  output logic                        clip_flag_pin_oe,
  output logic                        addr_fault_pin_o,
  output logic                        addr_fault_pin_oe
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = $bits(afs_pkg::afs_sense_t) + 6;
  logic [SW-1:0]       sync1;          // First stage, read only by sync2
  logic [SW-1:0]       sync2;          // Usable stage
  afs_pkg::afs_sense_t s;              // Synchronised comparators
  logic [1:0]          mode_s;         // Synchronised mode pins
  logic                strap_s;        // Synchronised strap
  logic                stby_s;         // Synchronised standby
  logic                tick_s;         // Synchronised PWM tick level
  logic                tick_d;         // Delayed tick for edge

  // Two flops on every pin and comparator input
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
      tick_d <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1 <= {sense, mode_pins, latch_enable_strap, standby, pwm_period_tick, converter_enable};
      sync2 <= sync1;
      tick_d <= tick_s;
    end
  end

  logic conv_s;                        // Synchronised converter enable
  assign {s, mode_s, strap_s, stby_s, tick_s, conv_s} = sync2;

  // Mode decoding, used in several places
  function automatic logic is_bus(input logic [1:0] m);
    is_bus = (m == afs_pkg::MODE_BUS_A) || (m == afs_pkg::MODE_BUS_B);
  endfunction

  logic bus_mode;                      // Bus operation selected
  logic pwm_edge;                      // One PWM period elapsed
  assign bus_mode = is_bus(mode_s);
  assign pwm_edge = tick_s & ~tick_d;

  // ---------------------------------------------------------------
  // Strap capture after reset release
  // ---------------------------------------------------------------
  logic       strap_taken;             // Strap already sampled
  logic       strap_val;               // Held thyristor enable from strap
  logic [1:0] strap_fill;              // Synchroniser fill marker after reset

  // Sampled once, on the third enabled edge; earlier the sync stages still hold reset zeros
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strap_fill  <= 2'h0;
      strap_taken <= 1'b0;
      strap_val   <= 1'b0;
    end
    else if (clk_en)
    begin
      strap_fill <= {strap_fill[0], 1'b1};
      if (strap_fill[1] && !strap_taken)
      begin
        strap_taken <= 1'b1;
        strap_val   <= strap_s;
      end
    end
  end

  logic thyristor_enable;              // Effective enable
  assign thyristor_enable = bus_mode ? thyristor_enable_bit : strap_val;

  // ---------------------------------------------------------------
  // Qualification counters
  // ---------------------------------------------------------------
  logic [afs_pkg::CNT_W-1:0] offset_cnt;   // Offset duration
  logic [afs_pkg::CNT_W-1:0] window_cnt;   // Sense window duration
  logic                      offset_qual;  // Offset held over 100ms
  logic                      window_qual;  // Window held over 100ms

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      offset_cnt <= '0;
      window_cnt <= '0;
    end
    else if (clk_en)
    begin
      if (!s.offset_over)
        offset_cnt <= '0;
      else if (!offset_qual)
        offset_cnt <= offset_cnt + 1'b1;
      if (!s.out_in_window)
        window_cnt <= '0;
      else if (!window_qual)
        window_cnt <= window_cnt + 1'b1;
    end
  end

  assign offset_qual = (offset_cnt == afs_pkg::CNT_W'(afs_pkg::OFFSET_QUAL_CYC));
  assign window_qual = (window_cnt == afs_pkg::CNT_W'(afs_pkg::WINDOW_QUAL_CYC));

  assign sense_switch_open = window_qual;

  logic sup_event;                     // Qualified supply over-current
  assign sup_event = s.sup_over & window_qual;

  // ---------------------------------------------------------------
  // Power-up diagnostic sequencer
  // ---------------------------------------------------------------
  afs_pkg::afs_diag_t        diag_st;      // Sequencer state
  logic [afs_pkg::CNT_W-1:0] diag_cnt;     // Test window count
  logic                      auto_done;    // Automatic run already made
  logic                      diag_start;   // Start request
  logic [3:0]                diag_hits;    // Live diagnostic comparators
  logic                      diag_on;      // Diagnostic running

  assign diag_hits = {s.diag_open, s.diag_short, s.diag_vs, s.diag_gnd};
  assign diag_start = bus_mode ? (wr_reg_one && wr_data[afs_pkg::F1_DIAG_RUN])
                               : (mode_s == afs_pkg::MODE_BUSFREE_DIAG) && !auto_done && strap_taken;
  assign diag_on = (diag_st == afs_pkg::AFS_TEST);

  // Runs the 100ms window; keeps running while a fault stays
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      diag_st   <= afs_pkg::AFS_IDLE;
      diag_cnt  <= '0;
      auto_done <= 1'b0;
    end
    else if (clk_en)
    begin
      case (diag_st)
        afs_pkg::AFS_IDLE:
        begin
          diag_cnt <= '0;
          if (diag_start)
          begin
            diag_st   <= afs_pkg::AFS_TEST;
            auto_done <= 1'b1;
          end
        end
        afs_pkg::AFS_TEST:
        begin
          // Window only ends once no fault is seen
          if (diag_hits != 4'h0)
            diag_cnt <= '0;
          else if (diag_cnt == afs_pkg::CNT_W'(afs_pkg::DIAG_QUAL_CYC))
            diag_st <= afs_pkg::AFS_DONE;
          else
            diag_cnt <= diag_cnt + 1'b1;
        end
        afs_pkg::AFS_DONE:
          diag_st <= afs_pkg::AFS_IDLE;
        default:
          diag_st <= afs_pkg::AFS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Fault register one (diagnostic results)
  // ---------------------------------------------------------------
  // Latch each diagnostic result; set wins over clear
  logic [3:0] diag_flag;               // Latched diagnostic results
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_diag
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          diag_flag[gi] <= 1'b0;
        else if (clk_en)
        begin
          if (diag_on && diag_hits[gi])
            diag_flag[gi] <= 1'b1;
          else if (wr_reg_one && wr_data[gi])
            diag_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Running bit reads back the sequencer; one driver for the whole word
  assign fault_reg_one = {3'h0, diag_on, diag_flag};

  // ---------------------------------------------------------------
  // Output over-current persistence
  // ---------------------------------------------------------------
  logic [2:0] oc_cnt;                  // PWM periods at second threshold
  logic       oc_trip2;                // Persisted beyond limit
  logic       oc_latched;              // Thyristor path latched off

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      oc_cnt <= 3'h0;
    else if (clk_en)
    begin
      if (!s.oc_th2)
        oc_cnt <= 3'h0;
      else if (pwm_edge && !oc_trip2)
        oc_cnt <= oc_cnt + 3'h1;
    end
  end

  // More than four periods
  assign oc_trip2 = (oc_cnt > 3'(afs_pkg::OC_PERSIST_PWM));
  assign current_inject = s.oc_th1;

  // ---------------------------------------------------------------
  // Fault register two (operating faults)
  // ---------------------------------------------------------------
  logic [5:0] f2_set;                  // Set events per flag
  logic       clip_now;                // Instantaneous clip

  assign clip_now = s.max_mod | s.oc_th1 | s.analog_output_clip;
  assign f2_set[afs_pkg::F2_OFFSET]    = offset_qual;   // Offset latch
  assign f2_set[afs_pkg::F2_TWARN]     = s.die_th1;     // Die warning
  assign f2_set[afs_pkg::F2_EXT_TWARN] = s.ext_th1;     // External warning
  assign f2_set[afs_pkg::F2_CLIP]      = clip_now;
  assign f2_set[afs_pkg::F2_OUT_TRIP]  = s.oc_th1;      // Trip flag
  assign f2_set[afs_pkg::F2_SUP_TRIP]  = sup_event;     // Supply trip

  logic [5:0] op_flag;                 // Latched operating faults

  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_f2
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          op_flag[gi] <= 1'b0;
        else if (clk_en)
        begin
          if (f2_set[gi])
            op_flag[gi] <= 1'b1;
          else if (wr_reg_two && wr_data[gi])
            op_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign fault_reg_two = {2'h0, op_flag};

  // ---------------------------------------------------------------
  // Offset lock in bus-free mode
  // ---------------------------------------------------------------
  logic offset_hold;                   // Offset held until standby

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      offset_hold <= 1'b0;
    else if (clk_en)
    begin
      if (offset_qual && !bus_mode)
        offset_hold <= 1'b1;
      else if (stby_s)
        offset_hold <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Thyristor and tristate
  // ---------------------------------------------------------------
  logic fire_req;                      // Fire condition this cycle

  assign fire_req = thyristor_enable & (s.die_th2 | s.ext_th2 | oc_trip2 | sup_event);

  // Stays fired until power is removed; reset stands for power-up
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      power_latch_thyristor <= 1'b0;
      oc_latched <= 1'b0;
    end
    else if (clk_en)
    begin
      if (fire_req)
        power_latch_thyristor <= 1'b1;
      if (oc_trip2 && thyristor_enable)
        oc_latched <= 1'b1;
    end
  end

  // Registered tristate; flag clear releases offset in bus mode
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      modulator_tristate <= 1'b0;
    else if (clk_en)
      modulator_tristate <= diag_on | oc_latched | offset_hold | offset_qual
                          | (bus_mode & fault_reg_two[afs_pkg::F2_OFFSET]);
  end

  // ---------------------------------------------------------------
  // Fault and clip pins
  // ---------------------------------------------------------------
  logic fault_any;                     // Bus-free fault pin source
  logic clip_pin_act;                  // Clip pin asserted
  logic fault_pin_act;                 // Fault pin asserted

  assign fault_any = (|fault_reg_one[3:0]) | s.die_th1 | s.ext_th1 | sup_event
                   | offset_hold | offset_qual;

  // Pins are registered so they never glitch
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clip_pin_act  <= 1'b0;
      fault_pin_act <= 1'b0;
    end
    else if (clk_en)
    begin
      clip_pin_act <= !bus_mode && clip_now;
      // Fault pin as clip while the converter is enabled, in either mode
      if (conv_s)
        fault_pin_act <= clip_now;
      else if (!bus_mode)
        fault_pin_act <= fault_any;
      else
        fault_pin_act <= 1'b0;
    end
  end

  assign i2c_addr0_force_zero = bus_mode & conv_s;
  // Open drain: pull low when asserted
  assign clip_flag_pin_o   = 1'b0;
  assign clip_flag_pin_oe  = clip_pin_act;
  assign addr_fault_pin_o  = 1'b0;
  assign addr_fault_pin_oe = fault_pin_act;

endmodule

/* testbench/afs_supervisor_checker.sv */
// Checker: concurrent properties on the fault supervisor ports
`timescale 1ns/1ps
module afs_supervisor_checker (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                clk_en,
  // Watched inputs
  input wire logic [1:0]          mode_pins,
  input wire logic                converter_enable,
  input wire afs_pkg::afs_sense_t sense,
  input wire logic                wr_reg_two,
  input wire logic [7:0]          wr_data,
  // Watched outputs
  input wire logic [7:0]          fault_reg_one,
  input wire logic [7:0]          fault_reg_two,
  input wire logic                modulator_tristate,
  input wire logic                current_inject,
  input wire logic                power_latch_thyristor,
  input wire logic                i2c_addr0_force_zero,
  input wire logic                clip_flag_pin_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Sticky records of any firing or tristate cause since reset
  logic fire_seen;
  logic tri_seen;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) fire_seen <= 1'b0;
    else fire_seen <= fire_seen | sense.die_th2 | sense.ext_th2 | sense.oc_th2 | sense.sup_over;
  // Diagnostics raise tristate one cycle after the running bit, so the flag is read live below
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) tri_seen <= 1'b0;
    else tri_seen <= tri_seen | sense.offset_over | sense.oc_th2;
  // Inputs must outlast the two sync flops and the flag register
  sequence s_die_warn;
    (sense.die_th1 && clk_en)[*6];
  endsequence
  sequence s_free_clip;
    (!mode_pins[1] && sense.max_mod && clk_en)[*6];
  endsequence
  sequence s_oc_first;
    (sense.oc_th1 && clk_en)[*4];
  endsequence
  AST_THY_HOLD: assert property (power_latch_thyristor |=> power_latch_thyristor)
    else $error("thyristor released without reset");
  AST_THY_CAUSE: assert property ($rose(power_latch_thyristor) |-> fire_seen)
    else $error("thyristor fired without cause");
  AST_TRI_CAUSE: assert property ($rose(modulator_tristate) |-> tri_seen || fault_reg_one[4] || fault_reg_two[0])
    else $error("tristate without cause");
  AST_CLIP_HOLD: assert property (fault_reg_two[3] && !(wr_reg_two && wr_data[3]) |=> fault_reg_two[3])
    else $error("clip flag lost without clear");
  AST_DIE_SET: assert property (s_die_warn |-> fault_reg_two[1])
    else $error("die warning not latched");
  AST_FREE_CLIP: assert property (s_free_clip |-> clip_flag_pin_oe)
    else $error("clip pin idle while clipping");
  AST_INJECT: assert property (s_oc_first |-> current_inject)
    else $error("no current injection");
  AST_ADDR0: assert property ((mode_pins[1] && converter_enable && clk_en)[*4] |-> i2c_addr0_force_zero)
    else $error("address bit not forced");
endmodule
bind afs_supervisor afs_supervisor_checker u_afs_supervisor_checker (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .mode_pins(mode_pins),
  .converter_enable(converter_enable), .sense(sense), .wr_reg_two(wr_reg_two),
  .wr_data(wr_data), .fault_reg_one(fault_reg_one), .fault_reg_two(fault_reg_two),
  .modulator_tristate(modulator_tristate), .current_inject(current_inject),
  .power_latch_thyristor(power_latch_thyristor), .i2c_addr0_force_zero(i2c_addr0_force_zero),
  .clip_flag_pin_oe(clip_flag_pin_oe)
);

/* testbench/afs_host_model.sv */
// Host model: turns bench requests into one-cycle register write strobes
`timescale 1ns/1ps
module afs_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Bench request
  input  wire logic       req,
  input  wire logic       req_sel,
  input  wire logic [7:0] req_data,
  // Write side
  output logic            wr_reg_one,
  output logic            wr_reg_two,
  output logic [7:0]      wr_data
);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_reg_one <= 1'b0;
      wr_reg_two <= 1'b0;
      wr_data    <= 8'h00;
    end
    else
    begin
      wr_reg_one <= req & ~req_sel;
      wr_reg_two <= req & req_sel;
      // Idle data flips each cycle so a stale word is never mistaken for valid
      wr_data    <= req ? req_data : ~wr_data;
    end
  end
endmodule

/* testbench/afs_supervisor_tb.sv */
// Testbench for the amplifier fault supervisor
`timescale 1ns/1ps
module afs_supervisor_tb;
  // Stimulus and host requests
  logic                clk_sys = 1'b0;
  logic                rst     = 1'b1;
  logic [1:0]          mode    = 2'h2;
  logic                strap   = 1'b0;
  logic                conv    = 1'b0;
  logic                tick    = 1'b0;
  logic                ten     = 1'b0;
  logic                req     = 1'b0;
  logic                rsel    = 1'b0;
  logic [7:0]          rdat    = 8'h00;
  afs_pkg::afs_sense_t sn      = '0;
  // Design outputs
  logic                wr1, wr2, tri_o, inj, thy, sw, a0, co, coe, ao, aoe;
  logic [7:0]          wd, f1, f2, m, r;
  logic [31:0]         seed    = 32'h5635;
  int                  n_errors = 0;
  int                  checks   = 0;
  int                  cycles   = 0;
  int                  k;
  int                  e;
  initial forever #12.5 clk_sys = ~clk_sys;
  afs_supervisor u_afs_supervisor (
    .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .mode_pins(mode), .latch_enable_strap(strap),
    .standby(1'b0), .converter_enable(conv), .pwm_period_tick(tick), .sense(sn), .wr_reg_one(wr1),
    .wr_reg_two(wr2), .wr_data(wd), .thyristor_enable_bit(ten), .fault_reg_one(f1), .fault_reg_two(f2),
    .modulator_tristate(tri_o), .current_inject(inj), .power_latch_thyristor(thy), .sense_switch_open(sw),
    .i2c_addr0_force_zero(a0), .clip_flag_pin_o(co), .clip_flag_pin_oe(coe), .addr_fault_pin_o(ao),
    .addr_fault_pin_oe(aoe)
  );
  afs_host_model u_afs_host_model (
    .clk_sys(clk_sys), .rst(rst), .req(req), .req_sel(rsel), .req_data(rdat),
    .wr_reg_one(wr1), .wr_reg_two(wr2), .wr_data(wd)
  );
  // Random source for clear masks
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Flag bits each source latches; current control also counts as clipping
  function automatic logic [7:0] exp_mask(input int i);
    case (i)
      0: return 8'h02;
      1: return 8'h04;
      2, 3: return 8'h08;
      default: return 8'h18;
    endcase
  endfunction
  // One comparator level per source index
  function automatic afs_pkg::afs_sense_t src(input int i);
    afs_pkg::afs_sense_t v;
    v = '0;
    case (i)
      0: v.die_th1 = 1'b1;
      1: v.ext_th1 = 1'b1;
      2: v.max_mod = 1'b1;
      3: v.analog_output_clip = 1'b1;
      4: v.oc_th1 = 1'b1;
      5: v.die_th2 = 1'b1;
      6: v.ext_th2 = 1'b1;
      8: v.diag_gnd = 1'b1;
      9: v.diag_vs = 1'b1;
      10: v.diag_short = 1'b1;
      11: v.diag_open = 1'b1;
      default: v.oc_th2 = 1'b1;
    endcase
    return v;
  endfunction
  // Wait edges, then step past them so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t output %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk_sys);
    req  <= 1'b1;
    rsel <= sel;
    rdat <= d;
    @(posedge clk_sys);
    req <= 1'b0;
    cyc(3);
  endtask
  task automatic drive(input afs_pkg::afs_sense_t v);
    @(posedge clk_sys);
    sn <= v;
    cyc(6);
  endtask
  task automatic rs(input logic [1:0] md, input logic st);
    @(posedge clk_sys);
    rst   <= 1'b1;
    mode  <= md;
    strap <= st;
    sn    <= '0;
    ten   <= 1'b0;
    conv  <= 1'b0;
    cyc(16);
    rst <= 1'b0;
    cyc(6);
  endtask
  // PWM periods: each rising edge is one period
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      tick <= 1'b1;
      cyc(2);
      tick <= 1'b0;
      cyc(2);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the roughly 600 cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    rs(2'h2, 1'b0);
    chk(f1, 8'h00);
    chb(tri_o | sw, 1'b0);
    for (k = 0; k < 5; k++)
    begin
      m = exp_mask(k);
      seed = xs(seed);
      r = seed[7:0] & ~m;
      drive(src(k));
      chk(f2, m);
      chb(inj, k == 4);
      wr(1'b1, m);
      chk(f2, m);
      drive('0);
      wr(1'b1, r);
      chk(f2, m);
      wr(1'b1, m | r);
      chk(f2, 8'h00);
    end
    rs(2'h0, 1'b0);
    for (k = 0; k < 5; k++)
    begin
      drive(src(k));
      chb(coe, k > 1);
      chb(aoe, k < 2);
      chb(co | ao, 1'b0);
      drive('0);
      chb(coe | aoe, 1'b0);
    end
    // clip routed to the fault pin
    rs(2'h3, 1'b0);
    conv <= 1'b1;
    drive(src(3));
    chb(aoe, 1'b1);
    chb(a0, 1'b1);
    drive('0);
    chb(aoe, 1'b0);
    for (k = 5; k < 7; k++)
    begin
      rs(2'h2, 1'b0);
      drive(src(k));
      chb(thy, 1'b0);
      ten <= 1'b1;
      cyc(6);
      chb(thy, 1'b1);
    end
    for (e = 0; e < 2; e++)
    begin
      rs(2'h2, 1'b0);
      ten <= e[0];
      drive(src(7));
      tk(4);
      chb(thy, 1'b0);
      tk(2);
      chb(thy, e[0]);
      chb(tri_o, e[0]);
    end
    rs(2'h0, 1'b1);
    drive(src(6));
    chb(thy, 1'b1);
    rs(2'h2, 1'b0);
    wr(1'b0, 8'h10);
    chk(f1 & 8'h10, 8'h10);
    chb(tri_o, 1'b1);
    // each diagnostic result latches while the run lasts
    for (k = 8; k < 12; k++)
    begin
      drive(src(k));
      chk(f1 & 8'h0F, 8'((1 << (k - 7)) - 1));
    end
    rs(2'h1, 1'b0);
    chk(f1 & 8'h10, 8'h10);
    end_of_test();
  end
endmodule
